// ==== modbus_link_pkg.sv ====
// constants of the serial slave link: register map, resets, codes and timing
// assumes a 250 MHz core clock and RTU framing on a half-duplex RS485 line
package modbus_link_pkg;

    localparam int          CLK_HZ        = 250_000_000;
    localparam int          NUM_REGS      = 6;

    // register indices from the base address
    localparam logic [15:0] REG_BASE      = 16'h01F4;
    localparam logic [2:0]  IDX_STATION   = 3'h0;
    localparam logic [2:0]  IDX_FRAME     = 3'h1;
    localparam logic [2:0]  IDX_STOP      = 3'h2;
    localparam logic [2:0]  IDX_PARITY    = 3'h3;
    localparam logic [2:0]  IDX_BAUD      = 3'h4;
    localparam logic [2:0]  IDX_PERMIT    = 3'h5;

    // reset values
    localparam logic [15:0] RST_STATION   = 16'h0001;
    localparam logic [15:0] RST_FRAME     = 16'h0000;
    localparam logic [15:0] RST_STOP      = 16'h0000;
    localparam logic [15:0] RST_PARITY    = 16'h0000;
    localparam logic [15:0] RST_BAUD      = 16'h0002;
    localparam logic [15:0] RST_PERMIT    = 16'h0001;

    // legal ranges, and the even parity code
    localparam logic [15:0] STATION_MIN   = 16'h0001;
    localparam logic [15:0] STATION_MAX   = 16'h00FE;
    localparam logic [15:0] BIT_MAX       = 16'h0001;
    localparam logic [15:0] PARITY_MAX    = 16'h0002;
    localparam logic [15:0] BAUD_MAX      = 16'h0005;
    localparam logic [15:0] PAR_EVEN      = 16'h0001;

    // frame layout
    localparam logic [7:0]  FN_READ       = 8'h03;
    localparam logic [7:0]  FN_WRITE      = 8'h06;
    localparam logic [3:0]  REQ_LEN       = 4'h8;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'hA001;

    // line rates by code, in bit/s
    localparam int          BAUD_0        = 2400;
    localparam int          BAUD_1        = 4800;
    localparam int          BAUD_2        = 9600;
    localparam int          BAUD_3        = 19200;
    localparam int          BAUD_4        = 38400;
    localparam int          BAUD_5        = 57600;

    // end-of-frame silence: 3.5 characters of 11 bits, rounded up to bit times
    localparam int          SILENCE_BITS  = 39;

endpackage : modbus_link_pkg

// ==== modbus_rs485_slave_link.sv ====
// RTU serial slave for the link settings of a servo drive on an RS485 bus
// assumes rxd comes from the transceiver already synchronous to clk, and that
// tx_drive_en steers the transceiver driver (high drives the pair)
`timescale 1ns/10ps
module modbus_rs485_slave_link #(
    parameter int          CLK_HZ       = modbus_link_pkg::CLK_HZ,
    parameter logic [15:0] PERMIT_RESET = modbus_link_pkg::RST_PERMIT
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_drive_en,
    output logic [15:0]      station_address,
    output logic [15:0]      frame_mode_select,
    output logic [15:0]      stop_bit_select,
    output logic [15:0]      parity_select,
    output logic [15:0]      baud_rate_select,
    output logic [15:0]      link_access_permit,
    output logic             param_wr_pulse,
    output logic [2:0]       param_wr_index,
    output logic [15:0]      param_wr_data
);

    typedef enum logic {RX_IDLE, RX_BUSY} rx_state_e;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ modbus_link_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    function automatic logic [19:0] bit_div(input logic [15:0] code);
        case (code)
            16'h0000: bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_0);
            16'h0001: bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_1);
            16'h0003: bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_3);
            16'h0004: bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_4);
            16'h0005: bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_5);
            default:  bit_div = 20'(CLK_HZ / modbus_link_pkg::BAUD_2);
        endcase
    endfunction : bit_div

    function automatic logic value_ok(input logic [2:0] idx, input logic [15:0] v);
        if (idx == modbus_link_pkg::IDX_STATION) begin
            value_ok = v >= modbus_link_pkg::STATION_MIN && v <= modbus_link_pkg::STATION_MAX;
        end else if (idx == modbus_link_pkg::IDX_FRAME || idx == modbus_link_pkg::IDX_STOP) begin
            value_ok = v <= modbus_link_pkg::BIT_MAX;
        end else if (idx == modbus_link_pkg::IDX_PARITY) begin
            value_ok = v <= modbus_link_pkg::PARITY_MAX;
        end else if (idx == modbus_link_pkg::IDX_BAUD) begin
            value_ok = v <= modbus_link_pkg::BAUD_MAX;
        end else begin
            value_ok = 1'b1;
        end
    endfunction : value_ok

    logic [15:0] cfg_q [modbus_link_pkg::NUM_REGS];
    logic [15:0] cfg_d [modbus_link_pkg::NUM_REGS];
    logic [7:0]  buf_q [8];
    logic [7:0]  buf_d [8];
    rx_state_e   rx_state_q, rx_state_d;
    tx_state_e   tx_state_q, tx_state_d;
    logic [19:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d, div;
    logic [3:0]  rx_bit_q, rx_bit_d, tx_bit_q, tx_bit_d, len_q, len_d, stop_pos, last_pos;
    logic [7:0]  rx_sh_q, rx_sh_d, tx_byte_q, tx_byte_d, next_byte;
    logic [15:0] crc_q, crc_d, tx_crc_q, tx_crc_d, reg_off, req_val, rd_word;
    logic [25:0] idle_q, idle_d, gap;
    logic        bad_q, bad_d, txd_q, txd_d, echo_q, echo_d, wr_q, wr_d;
    logic [4:0]  tx_idx_q, tx_idx_d, tx_len_q, tx_len_d, rd_pos, nxt_idx;
    logic [2:0]  rd_base_q, rd_base_d, wr_idx_q, wr_idx_d, idx;
    logic [15:0] wr_data_q, wr_data_d;
    logic        par_on, frame_end, frame_ok, wr_ok, rd_ok;

    localparam logic [15:0] PAR_EVEN_C = modbus_link_pkg::PAR_EVEN;

    // settings in use come straight from the stored registers, so a new code acts at once
    assign div      = bit_div(cfg_q[modbus_link_pkg::IDX_BAUD]);
    assign par_on   = cfg_q[modbus_link_pkg::IDX_PARITY] != 16'h0000;
    assign stop_pos = par_on ? 4'hA : 4'h9;
    assign last_pos = stop_pos + {3'h0, cfg_q[modbus_link_pkg::IDX_STOP][0]};
    assign gap      = 26'(div * modbus_link_pkg::SILENCE_BITS);

    // request decode, evaluated once when the line has been quiet for 3.5 characters
    assign frame_end = rx_state_q == RX_IDLE && len_q != 4'h0 && idle_q >= gap;
    assign reg_off   = {buf_q[2], buf_q[3]} - modbus_link_pkg::REG_BASE;
    assign idx       = reg_off[2:0];
    assign req_val   = {buf_q[4], buf_q[5]};
    // ascii framing (mode 1) is not decoded; the drive then stays silent
    assign frame_ok  = len_q == modbus_link_pkg::REQ_LEN && !bad_q && crc_q == 16'h0000
                     && {8'h00, buf_q[0]} == cfg_q[modbus_link_pkg::IDX_STATION]
                     && cfg_q[modbus_link_pkg::IDX_FRAME] == 16'h0000;
    assign wr_ok     = frame_ok && buf_q[1] == modbus_link_pkg::FN_WRITE
                     && reg_off < 16'(modbus_link_pkg::NUM_REGS) && value_ok(idx, req_val)
                     && (cfg_q[modbus_link_pkg::IDX_PERMIT] != 16'h0000
                         || idx == modbus_link_pkg::IDX_PERMIT);
    assign rd_ok     = frame_ok && buf_q[1] == modbus_link_pkg::FN_READ && req_val != 16'h0000
                     && reg_off < 16'(modbus_link_pkg::NUM_REGS)
                     // one extra bit so a huge count cannot wrap past the end check
                     && {1'b0, reg_off} + {1'b0, req_val} <= 17'(modbus_link_pkg::NUM_REGS);

    // receiver: sampling at mid bit, and locked out while the drive talks
    always_comb begin
        rx_state_d = rx_state_q;
        rx_cnt_d   = rx_cnt_q;
        rx_bit_d   = rx_bit_q;
        rx_sh_d    = rx_sh_q;
        buf_d      = buf_q;
        len_d      = len_q;
        crc_d      = crc_q;
        bad_d      = bad_q;
        idle_d     = (rx_state_q == RX_BUSY || !rxd) ? 26'h0 : (idle_q >= gap ? idle_q : idle_q + 26'h1);
        if (frame_end) begin
            len_d = 4'h0;
            crc_d = modbus_link_pkg::CRC_INIT;
            bad_d = 1'b0;
        end
        case (rx_state_q)
            RX_IDLE: begin
                if (!rxd && tx_state_q == TX_IDLE) begin
                    rx_state_d = RX_BUSY;
                    rx_cnt_d   = div >> 1;
                    rx_bit_d   = 4'h0;
                end
            end
            RX_BUSY: begin
                if (rx_cnt_q != 20'h0) begin
                    rx_cnt_d = rx_cnt_q - 20'h1;
                end else begin
                    rx_cnt_d = div - 20'h1;
                    rx_bit_d = rx_bit_q + 4'h1;
                    if (rx_bit_q == 4'h0 && rxd) begin
                        rx_state_d = RX_IDLE;                       // glitch, not a start bit
                    end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
                        rx_sh_d = {rxd, rx_sh_q[7:1]};
                    end else if (rx_bit_q == 4'h9 && par_on) begin
                        if (rxd != ((^rx_sh_q) ^ (cfg_q[modbus_link_pkg::IDX_PARITY] != PAR_EVEN_C)))
                            bad_d = 1'b1;
                    end else if (rx_bit_q == stop_pos) begin
                        rx_state_d = RX_IDLE;
                        if (!rxd || len_q == modbus_link_pkg::REQ_LEN) begin
                            bad_d = 1'b1;                           // framing error or overlong
                        end else begin
                            buf_d[len_q[2:0]] = rx_sh_q;
                            len_d = len_q + 4'h1;
                            crc_d = crc_step(crc_q, rx_sh_q);
                        end
                    end
                end
            end
            default: rx_state_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state_q <= RX_IDLE;
            rx_cnt_q   <= 20'h0;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            buf_q      <= '{default: 8'h00};
            len_q      <= 4'h0;
            crc_q      <= modbus_link_pkg::CRC_INIT;
            bad_q      <= 1'b0;
            idle_q     <= 26'h0;
        end else begin
            rx_state_q <= rx_state_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_bit_q   <= rx_bit_d;
            rx_sh_q    <= rx_sh_d;
            buf_q      <= buf_d;
            len_q      <= len_d;
            crc_q      <= crc_d;
            bad_q      <= bad_d;
            idle_q     <= idle_d;
        end
    end

    // parameter store: a good write is taken in the same cycle, no commit step
    always_comb begin
        cfg_d     = cfg_q;
        wr_d      = 1'b0;
        wr_idx_d  = wr_idx_q;
        wr_data_d = wr_data_q;
        if (frame_end && wr_ok) begin
            cfg_d[idx] = req_val;
            wr_d       = 1'b1;
            wr_idx_d   = idx;
            wr_data_d  = req_val;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q     <= '{modbus_link_pkg::RST_STATION, modbus_link_pkg::RST_FRAME,
                           modbus_link_pkg::RST_STOP, modbus_link_pkg::RST_PARITY,
                           modbus_link_pkg::RST_BAUD, PERMIT_RESET};
            wr_q      <= 1'b0;
            wr_idx_q  <= 3'h0;
            wr_data_q <= 16'h0000;
        end else begin
            cfg_q     <= cfg_d;
            wr_q      <= wr_d;
            wr_idx_q  <= wr_idx_d;
            wr_data_q <= wr_data_d;
        end
    end

    // reply byte after tx_idx: echo copies the request, crc included; reads build data then crc
    // picked from the registered index so the choice never loops through the next-state logic
    assign nxt_idx = tx_idx_q + 5'h1;
    assign rd_pos  = nxt_idx - 5'h3;
    assign rd_word = cfg_q[3'(rd_base_q + 3'(rd_pos[4:1]))];
    always_comb begin
        if (echo_q) begin
            next_byte = buf_q[nxt_idx[2:0]];
        end else if (nxt_idx == 5'h1) begin
            next_byte = modbus_link_pkg::FN_READ;
        end else if (nxt_idx == 5'h2) begin
            next_byte = 8'(tx_len_q - 5'h5);
        end else if (nxt_idx == tx_len_q - 5'h2) begin
            next_byte = tx_crc_q[7:0];
        end else if (nxt_idx == tx_len_q - 5'h1) begin
            next_byte = tx_crc_q[15:8];
        end else begin
            next_byte = rd_pos[0] ? rd_word[7:0] : rd_word[15:8];
        end
    end

    // transmitter: start, 8 data lsb first, optional parity, one or two stop bits
    always_comb begin
        tx_state_d = tx_state_q;
        tx_cnt_d   = tx_cnt_q;
        tx_bit_d   = tx_bit_q;
        tx_idx_d   = tx_idx_q;
        tx_len_d   = tx_len_q;
        tx_byte_d  = tx_byte_q;
        tx_crc_d   = tx_crc_q;
        echo_d     = echo_q;
        rd_base_d  = rd_base_q;
        txd_d      = txd_q;
        case (tx_state_q)
            TX_IDLE: begin
                if (frame_end && (wr_ok || rd_ok)) begin
                    tx_state_d = TX_SEND;
                    echo_d     = wr_ok;
                    rd_base_d  = idx;
                    tx_len_d   = wr_ok ? 5'h8 : 5'(req_val[2:0] * 2 + 5);
                    tx_idx_d   = 5'h0;
                    tx_byte_d  = buf_q[0];
                    tx_crc_d   = crc_step(modbus_link_pkg::CRC_INIT, buf_q[0]);
                    tx_bit_d   = 4'h0;
                    // start bit already at the rate being written, so the echo is one rate
                    tx_cnt_d   = bit_div(cfg_d[modbus_link_pkg::IDX_BAUD]) - 20'h1;
                    txd_d      = 1'b0;
                end
            end
            TX_SEND: begin
                if (tx_cnt_q != 20'h0) begin
                    tx_cnt_d = tx_cnt_q - 20'h1;
                end else begin
                    tx_cnt_d = div - 20'h1;
                    tx_bit_d = tx_bit_q + 4'h1;
                    if (tx_bit_q < 4'h8) begin
                        txd_d = tx_byte_q[tx_bit_q[2:0]];
                    end else if (tx_bit_q == 4'h8 && par_on) begin
                        txd_d = (^tx_byte_q) ^ (cfg_q[modbus_link_pkg::IDX_PARITY] != PAR_EVEN_C);
                    end else if (tx_bit_q < last_pos) begin
                        txd_d = 1'b1;
                    end else if (tx_idx_q + 5'h1 < tx_len_q) begin
                        tx_idx_d  = tx_idx_q + 5'h1;
                        tx_byte_d = next_byte;
                        if (tx_idx_q + 5'h3 < tx_len_q)
                            tx_crc_d = crc_step(tx_crc_q, next_byte);
                        tx_bit_d  = 4'h0;
                        txd_d     = 1'b0;
                    end else begin
                        tx_state_d = TX_IDLE;                       // release the pair
                        txd_d      = 1'b1;
                    end
                end
            end
            default: tx_state_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_cnt_q   <= 20'h0;
            tx_bit_q   <= 4'h0;
            tx_idx_q   <= 5'h0;
            tx_len_q   <= 5'h0;
            tx_byte_q  <= 8'h00;
            tx_crc_q   <= modbus_link_pkg::CRC_INIT;
            echo_q     <= 1'b0;
            rd_base_q  <= 3'h0;
            txd_q      <= 1'b1;
        end else begin
            tx_state_q <= tx_state_d;
            tx_cnt_q   <= tx_cnt_d;
            tx_bit_q   <= tx_bit_d;
            tx_idx_q   <= tx_idx_d;
            tx_len_q   <= tx_len_d;
            tx_byte_q  <= tx_byte_d;
            tx_crc_q   <= tx_crc_d;
            echo_q     <= echo_d;
            rd_base_q  <= rd_base_d;
            txd_q      <= txd_d;
        end
    end

    assign txd                = txd_q;
    assign tx_drive_en        = tx_state_q == TX_SEND;
    assign station_address    = cfg_q[modbus_link_pkg::IDX_STATION];
    assign frame_mode_select  = cfg_q[modbus_link_pkg::IDX_FRAME];
    assign stop_bit_select    = cfg_q[modbus_link_pkg::IDX_STOP];
    assign parity_select      = cfg_q[modbus_link_pkg::IDX_PARITY];
    assign baud_rate_select   = cfg_q[modbus_link_pkg::IDX_BAUD];
    assign link_access_permit = cfg_q[modbus_link_pkg::IDX_PERMIT];
    assign param_wr_pulse     = wr_q;
    assign param_wr_index     = wr_idx_q;
    assign param_wr_data      = wr_data_q;

    sequence s_write_taken;
        frame_end && wr_ok && tx_state_q == TX_IDLE;
    endsequence
    sequence s_echo_started;
        tx_drive_en && echo_q && tx_len_q == 5'h8 && !txd;
    endsequence

    property p_half_duplex;
        @(posedge clk) disable iff (rst) tx_drive_en |-> rx_state_q == RX_IDLE;
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("receiver active while driving");
    property p_addressed;
        @(posedge clk) disable iff (rst) $rose(tx_drive_en) |-> $past(frame_ok);
    endproperty
    a_addressed: assert property (p_addressed) else $error("reply without own address");
    property p_store_now;
        @(posedge clk) disable iff (rst) frame_end && wr_ok |=> param_wr_pulse
            && param_wr_index == $past(idx) && cfg_q[param_wr_index] == $past(req_val);
    endproperty
    a_store_now: assert property (p_store_now) else $error("written value not stored");
    property p_baud_range;
        @(posedge clk) disable iff (rst) baud_rate_select <= modbus_link_pkg::BAUD_MAX;
    endproperty
    a_baud_range: assert property (p_baud_range) else $error("baud code out of range");
    property p_parity_range;
        @(posedge clk) disable iff (rst) parity_select <= modbus_link_pkg::PARITY_MAX;
    endproperty
    a_parity_range: assert property (p_parity_range) else $error("parity code out of range");
    property p_echo;
        @(posedge clk) disable iff (rst) s_write_taken |=> s_echo_started ##1 tx_drive_en;
    endproperty
    a_echo: assert property (p_echo) else $error("write not echoed");
    property p_station;
        @(posedge clk) disable iff (rst) station_address >= 16'h0001
            && station_address <= 16'h00FE && frame_mode_select <= 16'h0001
            && stop_bit_select <= 16'h0001;
    endproperty
    a_station: assert property (p_station) else $error("link setting out of range");

endmodule : modbus_rs485_slave_link

// ==== modbus_host_model.sv ====
// host end of the RS485 pair: sends RTU requests and collects the replies
// assumes no parity, one stop bit, and bias resistors that pull an idle pair high
`timescale 1ns/10ps
module modbus_host_model (
    input  wire logic clk,
    output logic      rxd,
    input  wire logic txd,
    input  wire logic tx_drive_en
);
    logic [63:0] tx_f;
    logic [63:0] rx_f;
    logic        line;

    // a released pair idles high through the bias network, never at the last bit
    assign line = (tx_drive_en === 1'b1) ? txd : 1'b1;
    initial rxd = 1'b1;

    // crc16 over six bytes, first byte in the top bits
    function automatic logic [15:0] crc16(input logic [47:0] m);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 5; i >= 0; i--) begin
            c = c ^ {8'h00, m[i*8 +: 8]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction : crc16

    // one request, framed with the settings the drive holds
    task automatic send_frame(input logic [7:0] adr, input logic [7:0] fn,
                              input logic [15:0] regn, input logic [15:0] val,
                              input int div);
        logic [15:0] c;
        logic [9:0]  bits;
        c    = crc16({adr, fn, regn, val});
        tx_f = {adr, fn, regn, val, c[7:0], c[15:8]};
        @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            bits = {1'b1, tx_f[i*8 +: 8], 1'b0};
            for (int k = 0; k < 10; k++) begin
                rxd <= bits[k];
                repeat (div) @(posedge clk);
            end
        end
    endtask : send_frame

    // listens only; got stays low when no start bit shows within lim0 clocks
    task automatic recv(input int div, input int lim0, output logic got);
        int         lim;
        int         t;
        logic [7:0] sh;
        got  = 1'b0;
        rx_f = '0;
        for (int i = 0; i < 8; i++) begin
            lim = (i == 0) ? lim0 : 2 * div;
            for (t = 0; t < lim && line !== 1'b0; t++) @(posedge clk);
            if (line !== 1'b0) return;
            repeat (div / 2) @(posedge clk);
            for (int k = 0; k < 9; k++) begin
                repeat (div) @(posedge clk);
                if (k < 8) sh[k] = line;
            end
            rx_f = {rx_f[55:0], sh};
        end
        got = 1'b1;
    endtask : recv
endmodule : modbus_host_model

// ==== tb_top.sv ====
// self-checking bench for the RS485 slave link, driven through the host model
// assumes a lowered core rate so that one bit lasts 100 clocks at code 2
`timescale 1ns/10ps
module tb_top;
    localparam int CLK_HZ = 960_000;
    localparam int DIV2   = CLK_HZ / 9600;
    localparam int DIV3   = CLK_HZ / 19200;
    logic        clk;
    logic        rst;
    logic        rxd;
    logic        txd;
    logic        tx_drive_en;
    logic [15:0] station_address;
    logic [15:0] frame_mode_select;
    logic [15:0] stop_bit_select;
    logic [15:0] parity_select;
    logic [15:0] baud_rate_select;
    logic [15:0] link_access_permit;
    logic        param_wr_pulse;
    logic [2:0]  param_wr_index;
    logic [15:0] param_wr_data;
    logic        got;
    int          failures = 0;
    int          n_checks = 0;
    int          wr_count = 0;

    modbus_rs485_slave_link #(.CLK_HZ(CLK_HZ)) dut (
        .clk(clk), .rst(rst), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en),
        .station_address(station_address), .frame_mode_select(frame_mode_select),
        .stop_bit_select(stop_bit_select), .parity_select(parity_select),
        .baud_rate_select(baud_rate_select), .link_access_permit(link_access_permit),
        .param_wr_pulse(param_wr_pulse), .param_wr_index(param_wr_index),
        .param_wr_data(param_wr_data)
    );
    modbus_host_model host (.clk(clk), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en));

    // clock, and a count of stored writes since each pulse lasts one cycle
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (param_wr_pulse === 1'b1) begin
            wr_count <= wr_count + 1;
        end
    end

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // defaults after reset, driver released
    task automatic t_reset;
        check("settings", 64'h0001_0000_0000_0000, {station_address, frame_mode_select,
              stop_bit_select, parity_select});
        check("baud", 16'h0002, baud_rate_select);
        check("drive_en", 1'b0, tx_drive_en);
        check("txd", 1'b1, txd);
        check("permit", 16'h0001, link_access_permit);
    endtask : t_reset

    // a two-register read returns the stored baud code and permit, then frees the pair
    task automatic t_read;
        int t;
        host.send_frame(8'hFE, 8'h03, 16'h01F8, 16'h0002, DIV3);
        host.recv(DIV3, 45 * DIV3, got);
        check("reply", 1'b1, got);
        check("read", 64'h00FE_0304_0003_0001, {8'h00, host.rx_f[63:8]});
        for (t = 0; t < 30 * DIV3 && tx_drive_en !== 1'b0; t++) @(posedge clk);
        check("drive_en", 1'b0, tx_drive_en);
    endtask : t_read

    // the echo of a rate change already comes back at the new rate
    task automatic t_write_baud;
        host.send_frame(8'h01, 8'h06, 16'h01F8, 16'h0003, DIV2);
        host.recv(DIV3, 45 * DIV2, got);
        check("reply", 1'b1, got);
        check("echo", host.tx_f, host.rx_f);
        check("baud", 16'h0003, baud_rate_select);
        check("wr_count", 64'h1, 64'(wr_count));
        check("wr_where", {3'h4, 16'h0003}, {param_wr_index, param_wr_data});
        repeat (2 * DIV3) @(posedge clk);
        check("drive_en", 1'b0, tx_drive_en);
    endtask : t_write_baud

    // a new station address is stored, and the old one is answered no more
    task automatic t_station;
        host.send_frame(8'h01, 8'h06, 16'h01F4, 16'h00FE, DIV3);
        host.recv(DIV3, 45 * DIV3, got);
        check("echo", host.tx_f, host.rx_f);
        check("station", 16'h00FE, station_address);
        repeat (2 * DIV3) @(posedge clk);
        host.send_frame(8'h01, 8'h06, 16'h01F7, 16'h0001, DIV3);
        host.recv(DIV3, 45 * DIV3, got);
        check("reply", 1'b0, got);
        check("parity", 16'h0000, parity_select);
    endtask : t_station

    // out-of-range codes change nothing and get no answer
    task automatic t_refused;
        logic [15:0] regs [0:5];
        logic [15:0] vals [0:5];
        regs = '{16'h01F8, 16'h01F7, 16'h01F4, 16'h01F4, 16'h01F5, 16'h01F6};
        vals = '{16'h0006, 16'h0003, 16'h0000, 16'h00FF, 16'h0002, 16'h0002};
        for (int i = 0; i < 6; i++) begin
            host.send_frame(8'hFE, 8'h06, regs[i], vals[i], DIV3);
            host.recv(DIV3, 45 * DIV3, got);
            check("reply", 1'b0, got);
        end
        check("settings", 64'h00FE_0000_0000_0000, {station_address, frame_mode_select,
              stop_bit_select, parity_select});
        check("baud", 16'h0003, baud_rate_select);
        check("wr_count", 64'h2, 64'(wr_count));
    endtask : t_refused

    // top parity code is taken; the echo itself is not decoded since it carries parity
    task automatic t_parity;
        int t;
        host.send_frame(8'hFE, 8'h06, 16'h01F7, 16'h0002, DIV3);
        for (t = 0; t < 45 * DIV3 && tx_drive_en !== 1'b1; t++) @(posedge clk);
        check("drive_en", 1'b1, tx_drive_en);
        check("parity", 16'h0002, parity_select);
        for (t = 0; t < 100 * DIV3 && tx_drive_en !== 1'b0; t++) @(posedge clk);
        check("drive_en", 1'b0, tx_drive_en);
        check("wr_count", 64'h3, 64'(wr_count));
    endtask : t_parity

    // main sequence
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_write_baud();
        t_station();
        t_refused();
        t_read();
        t_parity();
        summarize();
    end

    // cut a hung run short
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : tb_top
